// ---- hw/lstc_top.sv ----
// Line start trigger control: source selection, exposure timing, free-run
`timescale 1ns/1ps

module lstc_top (
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_b_in,
    input  wire logic [3:0]                 cc_lines_in,
    input  wire logic                       software_line_trigger_command_in,
    input  wire logic                       trigger_mode_on_in,
    input  wire logic [2:0]                 trigger_source_in,
    input  wire logic                       source_write_in,
    input  wire logic                       activation_falling_in,
    input  wire logic                       debounce_en_in,
    input  wire logic [lstc_pkg::DEB_W-1:0] debounce_raw_in,
    input  wire logic [lstc_pkg::RAW_W-1:0] exposure_raw_in,
    input  wire logic                       line_period_en_in,
    input  wire logic [lstc_pkg::RAW_W-1:0] line_period_raw_in,
    input  wire logic [lstc_pkg::RAW_W-1:0] min_line_period_raw_in,
    output logic [2:0]                      trigger_source_out,
    output logic                            software_line_trigger_command_out,
    output logic                            trigger_wait_out,
    output logic                            exposure_active_out,
    output logic                            line_start_out
);

    typedef enum logic [1:0] {
        LSTC_WAIT,
        LSTC_EXPOSE,
        LSTC_RECOVER
    } lstc_state_t;

    lstc_pkg::lstc_cfg_t              cfg;
    lstc_pkg::lstc_src_t              src_q;
    lstc_pkg::lstc_src_t              src_d;
    lstc_state_t                      state_q;
    lstc_state_t                      state_d;
    logic [3:0]                       tb_q;
    logic [3:0]                       tb_d;
    logic                             tick;
    logic [lstc_pkg::RAW_W-1:0]       exp_cnt_q;
    logic [lstc_pkg::RAW_W-1:0]       exp_cnt_d;
    logic [lstc_pkg::RAW_W-1:0]       per_cnt_q;
    logic [lstc_pkg::RAW_W-1:0]       per_cnt_d;
    logic [lstc_pkg::RAW_W-1:0]       eff_period;
    logic [1:0]                       gap_q;
    logic [1:0]                       gap_d;
    logic                             sw_cmd_q;
    logic                             sw_cmd_d;
    logic                             start_q;
    logic                             start_d;
    logic [lstc_pkg::DEB_W-1:0]       min_cyc;
    logic [3:0]                       rise;
    logic [3:0]                       fall;
    logic                             hw_edge;
    logic                             trig_req;
    logic                             free_req;

    // =========================================================
    // Configuration bundle; source comes from its own register
    always_comb begin
        cfg                     = '0;
        cfg.trigger_mode_on     = trigger_mode_on_in;
        cfg.source              = src_q;
        cfg.activation_falling  = activation_falling_in;
        cfg.debounce_en         = debounce_en_in;
        cfg.debounce_raw        = debounce_raw_in;
        cfg.exposure_raw        = exposure_raw_in;
        cfg.line_period_en      = line_period_en_in;
        cfg.line_period_raw     = line_period_raw_in;
        cfg.min_line_period_raw = min_line_period_raw_in;
    end

    // Source selector register; out-of-range codes are refused
    always_comb begin
        src_d = src_q;
        if (source_write_in && trigger_source_in <= 3'h4) begin
            src_d = lstc_pkg::lstc_src_t'(trigger_source_in);
        end
    end

    // =========================================================
    // Per-line filters; debouncer value never undercuts the 100 ns floor
    assign min_cyc = (cfg.debounce_en && cfg.debounce_raw > 16'(lstc_pkg::MIN_LEVEL_CYC))
                     ? cfg.debounce_raw : 16'(lstc_pkg::MIN_LEVEL_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_cc
            lstc_line_filter u_filt (
                .clk_sys_in    (clk_sys_in),
                .rst_b_in      (rst_b_in),
                .line_in       (cc_lines_in[gi]),
                .min_cycles_in (min_cyc),
                .rise_out      (rise[gi]),
                .fall_out      (fall[gi])
            );
        end
    endgenerate

    // =========================================================
    // Source select and edge polarity
    always_comb begin
        hw_edge = 1'b0;
        if (cfg.source != lstc_pkg::LSTC_SRC_SOFT) begin
            hw_edge = cfg.activation_falling ? fall[2'(cfg.source - 3'h1)]
                                             : rise[2'(cfg.source - 3'h1)];
        end
    end

    // Trigger request; only honoured in WAIT, so nothing queues
    assign trig_req = cfg.trigger_mode_on &&
                      ((cfg.source == lstc_pkg::LSTC_SRC_SOFT) ? sw_cmd_q : hw_edge);

    // Free-run period, capped so the rate never exceeds the maximum
    assign eff_period = (cfg.line_period_raw < cfg.min_line_period_raw)
                        ? cfg.min_line_period_raw : cfg.line_period_raw;
    assign free_req   = !cfg.trigger_mode_on && cfg.line_period_en && tick &&
                        (per_cnt_q + 24'h000001 >= eff_period);

    // =========================================================
    // 100 ns time base divider, one-cycle tick
    always_comb begin
        tick = (tb_q == 4'(lstc_pkg::TB_CYCLES - 1));
        tb_d = tick ? 4'h0 : tb_q + 4'h1;
    end

    // =========================================================
    // Acquisition sequencer and its counters
    always_comb begin
        state_d   = state_q;
        exp_cnt_d = exp_cnt_q;
        gap_d     = gap_q;
        start_d   = 1'b0;
        per_cnt_d = per_cnt_q;
        // Software command is held for one cycle, then cleared in any state
        sw_cmd_d  = sw_cmd_q | software_line_trigger_command_in;
        if (tick) begin
            per_cnt_d = free_req ? '0 : per_cnt_q + 24'h000001;
        end
        case (state_q)
            LSTC_WAIT: begin
                if (trig_req || free_req) begin
                    state_d   = LSTC_EXPOSE;
                    start_d   = 1'b1;
                    exp_cnt_d = cfg.exposure_raw;
                end
            end
            LSTC_EXPOSE: begin
                if (exp_cnt_q == '0) begin
                    state_d = LSTC_RECOVER;
                    gap_d   = 2'(lstc_pkg::RDY_GAP_CYC);
                end else if (tick) begin
                    exp_cnt_d = exp_cnt_q - 24'h000001;
                end
            end
            LSTC_RECOVER: begin
                if (gap_q == 2'h0) begin
                    state_d = LSTC_WAIT;
                end else begin
                    gap_d = gap_q - 2'h1;
                end
            end
            default: state_d = LSTC_WAIT;
        endcase
        // Command executes this cycle in WAIT or is dropped when busy
        if (sw_cmd_q) begin
            sw_cmd_d = software_line_trigger_command_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q   <= LSTC_WAIT;
            src_q     <= lstc_pkg::SRC_RESET;
            tb_q      <= 4'h0;
            exp_cnt_q <= '0;
            per_cnt_q <= '0;
            gap_q     <= 2'h0;
            sw_cmd_q  <= 1'b0;
            start_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            src_q     <= src_d;
            tb_q      <= tb_d;
            exp_cnt_q <= exp_cnt_d;
            per_cnt_q <= per_cnt_d;
            gap_q     <= gap_d;
            sw_cmd_q  <= sw_cmd_d;
            start_q   <= start_d;
        end
    end

    assign trigger_source_out                = src_q;
    assign software_line_trigger_command_out = sw_cmd_q;
    assign trigger_wait_out                  = (state_q == LSTC_WAIT);
    assign exposure_active_out               = (state_q == LSTC_EXPOSE);
    assign line_start_out                    = start_q;

    // =========================================================
    // Checks
    property p_src_reset;
        @(posedge clk_sys_in) $rose(rst_b_in) |-> src_q == lstc_pkg::LSTC_SRC_CC1;
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("source not CC1 after reset");

    property p_wait_leaves;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (trigger_wait_out && trig_req) |=> (!trigger_wait_out && line_start_out);
    endproperty
    a_wait_leaves: assert property (p_wait_leaves) else $error("trigger in wait did not start");

    property p_busy_ignore;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!trigger_wait_out) |=> !line_start_out;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("line start while busy");

    property p_cmd_clear;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (sw_cmd_q && !software_line_trigger_command_in) |=> !sw_cmd_q;
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("command did not self-clear");

    property p_wait_status;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        line_start_out |-> exposure_active_out && !trigger_wait_out;
    endproperty
    a_wait_status: assert property (p_wait_status) else $error("wait status wrong at start");

    property p_exp_load;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        line_start_out |-> exp_cnt_q == $past(cfg.exposure_raw);
    endproperty
    a_exp_load: assert property (p_exp_load) else $error("exposure not loaded");

    property p_exp_step;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (exposure_active_out && exp_cnt_q != '0 && tick) |=> exp_cnt_q == $past(exp_cnt_q) - 24'h000001;
    endproperty
    a_exp_step: assert property (p_exp_step) else $error("exposure count step wrong");

    property p_rdy_return;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (exposure_active_out && exp_cnt_q == '0) |-> ##4 trigger_wait_out;
    endproperty
    a_rdy_return: assert property (p_rdy_return) else $error("wait not re-entered");

    property p_mode_off;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!cfg.trigger_mode_on && !free_req && trigger_wait_out) |=> !line_start_out;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("trigger taken in mode off");

endmodule // lstc_top

// ---- hw/lstc_pkg.sv ----
// Package of constants and types for the line start trigger control block
package lstc_pkg;

    // =========================================================
    // Clock and time base
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned TIME_BASE_NS    = 100;
    localparam int unsigned MIN_LEVEL_NS    = 100;
    // Ticks of the core clock per 100 ns time base unit
    localparam int unsigned TB_CYCLES       = (TIME_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least level length without debouncer, rounded up
    localparam int unsigned MIN_LEVEL_CYC   = (MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =========================================================
    // Widths and ready gap length
    localparam int unsigned RAW_W           = 24;
    localparam int unsigned DEB_W           = 16;
    localparam int unsigned RDY_GAP_CYC     = 2;

    // =========================================================
    // Trigger source selector
    typedef enum logic [2:0] {
        LSTC_SRC_SOFT = 3'h0,
        LSTC_SRC_CC1  = 3'h1,
        LSTC_SRC_CC2  = 3'h2,
        LSTC_SRC_CC3  = 3'h3,
        LSTC_SRC_CC4  = 3'h4
    } lstc_src_t;

    localparam lstc_src_t SRC_RESET         = LSTC_SRC_CC1;

    // Configuration carried as one group
    typedef struct packed {
        logic             trigger_mode_on;
        lstc_src_t        source;
        logic             activation_falling;
        logic             debounce_en;
        logic [DEB_W-1:0] debounce_raw;
        logic [RAW_W-1:0] exposure_raw;
        logic             line_period_en;
        logic [RAW_W-1:0] line_period_raw;
        logic [RAW_W-1:0] min_line_period_raw;
    } lstc_cfg_t;

endpackage

// ---- hw/lstc_line_filter.sv ----
// Synchroniser and level filter for one control line input
`timescale 1ns/1ps

module lstc_line_filter (
    input  wire logic                       clk_sys_in,
    input  wire logic                       rst_b_in,
    input  wire logic                       line_in,
    input  wire logic [lstc_pkg::DEB_W-1:0] min_cycles_in,
    output logic                            rise_out,
    output logic                            fall_out
);

    logic                       sync1_q;
    logic                       sync2_q;
    logic                       level_q;
    logic                       level_d;
    logic [lstc_pkg::DEB_W-1:0] cnt_q;
    logic [lstc_pkg::DEB_W-1:0] cnt_d;
    logic [2:0]                 fill_q;
    logic [2:0]                 fill_d;

    // =========================================================
    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= line_in;
            sync2_q <= sync1_q;
        end
    end

    // =========================================================
    // A new level is accepted once it has stood for min_cycles
    // Until the synchroniser has filled, the level just follows it, so a line
    // that rests high gives no false edge after reset
    always_comb begin
        fill_d  = {fill_q[1:0], 1'b1};
        level_d = level_q;
        cnt_d   = '0;
        if (!fill_q[2]) begin
            level_d = sync2_q;
        end else if (sync2_q != level_q) begin
            if (cnt_q + 16'h0001 >= min_cycles_in) begin
                level_d = sync2_q;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            level_q <= 1'b0;
            cnt_q   <= '0;
            fill_q  <= 3'h0;
        end else begin
            level_q <= level_d;
            cnt_q   <= cnt_d;
            fill_q  <= fill_d;
        end
    end

    assign rise_out = fill_q[2] && (level_d != level_q) && level_d;
    assign fall_out = fill_q[2] && (level_d != level_q) && !level_d;

endmodule // lstc_line_filter

// ---- sim/lstc_fg_model.sv ----
// Frame grabber model that drives one trigger pulse on a control line
`timescale 1ns/1ps

module lstc_fg_model #(
    parameter logic [3:0] IDLE = 4'h0
) (
    input  wire logic        clk_sys_in,
    input  wire logic        req_in,
    input  wire logic [1:0]  line_sel_in,
    input  wire logic [15:0] len_in,
    output logic [3:0]       cc_lines_out,
    output logic             busy_out
);
    logic [15:0] cnt_q   = 16'h0;
    logic [1:0]  sel_q   = 2'h0;
    logic        act_q   = 1'b0;
    logic        busy_q  = 1'b0;
    logic [3:0]  lines_q = IDLE;

    // Outputs come from registers that start at rest, one driver each
    assign cc_lines_out = lines_q;
    assign busy_out     = busy_q;

    // ==========================================
    // Pulse engine
    // Leaves idle, holds the level, then holds idle just as long so both levels meet the minimum
    always @(posedge clk_sys_in) begin
        if (req_in && !busy_q) begin
            busy_q <= 1'b1;
            act_q <= 1'b1;
            sel_q <= line_sel_in;
            cnt_q <= len_in;
            lines_q[line_sel_in] <= ~IDLE[line_sel_in];
        end else if (busy_q) begin
            if (cnt_q > 16'h1) begin
                cnt_q <= cnt_q - 16'h1;
            end else if (act_q) begin
                act_q <= 1'b0;
                cnt_q <= len_in;
                lines_q[sel_q] <= IDLE[sel_q];
            end else begin
                busy_q <= 1'b0;
            end
        end
    end
endmodule // lstc_fg_model

// ---- sim/lstc_top_tb_top.sv ----
// Self-checking testbench for the line start trigger control block
`timescale 1ns/1ps

module lstc_top_tb_top;
    // Row: source, polarity, debounce, exposure, pulse length, latency window
    typedef struct {
        logic [2:0]  src;
        logic        fall;
        logic [15:0] deb;
        logic [23:0] expo;
        int          len;
        int          lo;
        int          hi;
    } lstc_row_t;

    // ==========================================
    // Signals
    logic        clk_sys_in = 1'b0;
    logic        rst_b      = 1'b0;
    logic        cmd        = 1'b0;
    logic        mode_on    = 1'b0;
    logic [2:0]  src        = 3'h0;
    logic        src_wr     = 1'b0;
    logic        fall       = 1'b0;
    logic        deb_en     = 1'b0;
    logic [15:0] deb_raw    = 16'h0;
    logic [23:0] expo_raw   = 24'h14;
    logic        per_en     = 1'b0;
    logic [23:0] per_raw    = 24'h1e;
    logic [23:0] min_raw    = 24'ha;
    logic        req        = 1'b0;
    logic [1:0]  sel        = 2'h0;
    logic [15:0] len        = 16'h1e;
    logic [3:0]  cc_lines;
    logic [2:0]  src_o;
    logic        cmd_o;
    logic        wait_o;
    logic        expo_o;
    logic        start_o;
    int          err_total  = 0;
    int          tests_run  = 0;

    // Exposures stay at or above 20 raw counts, the legal minimum
    lstc_row_t rows [6] = '{
        '{3'h0, 1'b0, 16'h0, 24'h14, 0, 2, 2},
        '{3'h1, 1'b0, 16'h0, 24'h19, 30, 11, 19},
        '{3'h2, 1'b1, 16'h0, 24'h15, 30, 41, 49},
        '{3'h3, 1'b1, 16'h0, 24'h1e, 10, 11, 19},
        '{3'h4, 1'b0, 16'h14, 24'h16, 30, 50, 60},
        '{3'h1, 1'b0, 16'h0, 24'h14, 10, 11, 19}
    };

    // Clock of 100 MHz
    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================
    // Design and frame grabber; CC3 and CC4 rest high
    lstc_top i_lstc_top (
        .clk_sys_in                       (clk_sys_in),
        .rst_b_in                         (rst_b),
        .cc_lines_in                      (cc_lines),
        .software_line_trigger_command_in (cmd),
        .trigger_mode_on_in               (mode_on),
        .trigger_source_in                (src),
        .source_write_in                  (src_wr),
        .activation_falling_in            (fall),
        .debounce_en_in                   (deb_en),
        .debounce_raw_in                  (deb_raw),
        .exposure_raw_in                  (expo_raw),
        .line_period_en_in                (per_en),
        .line_period_raw_in               (per_raw),
        .min_line_period_raw_in           (min_raw),
        .trigger_source_out               (src_o),
        .software_line_trigger_command_out(cmd_o),
        .trigger_wait_out                 (wait_o),
        .exposure_active_out              (expo_o),
        .line_start_out                   (start_o)
    );
    lstc_fg_model #(.IDLE(4'hc)) i_lstc_fg_model (
        .clk_sys_in  (clk_sys_in),
        .req_in      (req),
        .line_sel_in (sel),
        .len_in      (len),
        .cc_lines_out(cc_lines),
        .busy_out    ()
    );

    // ==========================================
    // Compare tasks and verdict
    task automatic chk_bit(string what, logic exp, logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_vec(string what, logic [2:0] exp, logic [2:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_num(string what, int lo, int hi, int got);
        tests_run++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Drivers; requests last one cycle and are cleared by the waiting tasks
    task automatic set_src(logic [2:0] s);
        @(negedge clk_sys_in);
        src = s;
        src_wr = 1'b1;
        @(negedge clk_sys_in);
        src_wr = 1'b0;
        chk_vec("source", s, src_o);
    endtask
    task automatic fire(logic [2:0] s, int l);
        @(negedge clk_sys_in);
        if (s == 3'h0) begin
            cmd = 1'b1;
        end else begin
            sel = 2'(s - 3'h1);
            len = 16'(l);
            req = 1'b1;
        end
    endtask
    task automatic wait_start(int max, output int n);
        n = 0;
        do begin
            @(negedge clk_sys_in);
            n++;
            cmd = 1'b0;
            req = 1'b0;
        end while (start_o !== 1'b1 && n < max);
        if (start_o !== 1'b1) begin
            err_total++;
            $display("unexpected line start: expected pulse seen none");
            give_verdict();
        end
    endtask
    task automatic quiet(int cyc);
        int c;
        c = 0;
        repeat (cyc) begin
            @(negedge clk_sys_in);
            cmd = 1'b0;
            req = 1'b0;
            if (start_o === 1'b1) c++;
        end
        chk_num("stray line starts", 0, 0, c);
    endtask
    // Exposure length in cycles, minus those already spent, then the return to waiting
    task automatic check_line(logic [23:0] raw, int done);
        int e;
        int x;
        e = 0;
        x = int'(raw) * int'(lstc_pkg::TB_CYCLES) - done;
        chk_bit("wait in exposure", 1'b0, wait_o);
        chk_bit("exposure running", 1'b1, expo_o);
        chk_bit("command self clear", 1'b0, cmd_o);
        while (expo_o === 1'b1 && e < 3000) begin
            e++;
            @(negedge clk_sys_in);
        end
        chk_num("exposure cycles", x - 10, x + 10, e);
        if (e >= 3000) give_verdict();
        for (int k = 0; k < 8 && wait_o !== 1'b1; k++) @(negedge clk_sys_in);
        chk_bit("wait after line", 1'b1, wait_o);
        if (wait_o !== 1'b1) give_verdict();
    endtask

    // ==========================================
    // Main sequence
    initial begin
        int n;
        repeat (11) @(negedge clk_sys_in);
        chk_vec("source at reset", lstc_pkg::SRC_RESET, src_o);
        chk_bit("wait at reset", 1'b1, wait_o);
        @(negedge clk_sys_in);
        rst_b = 1'b1;
        mode_on = 1'b1;
        foreach (rows[i]) begin
            fall = rows[i].fall;
            deb_en = (rows[i].deb != 16'h0);
            deb_raw = rows[i].deb;
            expo_raw = rows[i].expo;
            set_src(rows[i].src);
            fire(rows[i].src, rows[i].len);
            wait_start(100, n);
            chk_num("start latency", rows[i].lo, rows[i].hi, n);
            check_line(rows[i].expo, 0);
        end
        // Overtrigger: a command during exposure is dropped, not queued
        set_src(3'h0);
        fire(3'h0, 0);
        wait_start(10, n);
        fire(3'h0, 0);
        quiet(3);
        chk_bit("dropped command", 1'b0, cmd_o);
        check_line(expo_raw, 5);
        quiet(40);
        fire(3'h0, 0);
        wait_start(10, n);
        chk_num("start after ready", 2, 2, n);
        check_line(expo_raw, 0);
        // Sources that are not selected are ignored
        fire(3'h1, 30);
        quiet(80);
        set_src(3'h1);
        fire(3'h0, 0);
        quiet(40);
        set_src(3'h0);
        // A source code beyond CC4 is refused and the stored source stays
        @(negedge clk_sys_in);
        src = 3'h5;
        src_wr = 1'b1;
        @(negedge clk_sys_in);
        src_wr = 1'b0;
        chk_vec("refused source", 3'h0, src_o);
        mode_on = 1'b0;
        fire(3'h0, 0);
        quiet(40);
        // Free run, then capped by the shortest allowed period
        per_en = 1'b1;
        wait_start(1000, n);
        wait_start(1000, n);
        chk_num("line period", 290, 310, n);
        per_raw = 24'h19;
        min_raw = 24'h28;
        wait_start(1000, n);
        wait_start(1000, n);
        chk_num("capped period", 390, 410, n);
        per_en = 1'b0;
        quiet(600);
        // Reset in mid-run restores the default source
        rst_b = 1'b0;
        @(negedge clk_sys_in);
        chk_vec("source after reset", lstc_pkg::SRC_RESET, src_o);
        chk_bit("wait after reset", 1'b1, wait_o);
        chk_bit("no start in reset", 1'b0, start_o);
        // Release again; CC3 rests high, so a false edge out of reset would start a line
        @(negedge clk_sys_in);
        rst_b = 1'b1;
        fall = 1'b0;
        mode_on = 1'b1;
        set_src(3'h3);
        quiet(20);
        set_src(3'h0);
        fire(3'h0, 0);
        wait_start(10, n);
        chk_num("start after second reset", 2, 2, n);
        give_verdict();
    end
endmodule // lstc_top_tb_top
